// ### rtl/pin_fault_protection.sv
// Pin-fault supervisor of an active-clamp flyback controller.
//
// What this block does
// - Sense-pin short is judged only on the first low-side pulse after startup.
// - Silicon stage: end first pulse after 2 us, flag short, start recovery.
// - GaN stage: first-pulse cap 2 us if demag resistor high, else 1 us.
// - Sense above over-current level on three pulses in a row: open fault, recovery.
// - 10 us after turn-on, gate bias below 12 V forces one lockout cycle.
// - Gate bias over-voltage on three pulses in a row forces one lockout cycle.
// - After turn-on, programming pins are biased and their current judged open or short.
// - A faulty programming pin gives one lockout cycle instead of switching.
// - Recovery: no switching, run low, then normal start after timeout and turn-off.
`timescale 1ns/1ps
`default_nettype none

module pin_fault_protection #(
    parameter int unsigned RECOVERY_CYCLES = pin_fault_pkg::RECOVERY_CYC
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_pwm_request,
    input  wire logic i_supply_on,
    input  wire logic i_switch_type_select,
    input  wire logic i_demag_resistor_high,
    input  wire logic i_cs_over_limit,
    input  wire logic i_gate_bias_low,
    input  wire logic i_gate_bias_over,
    input  wire logic i_demag_pin_open,
    input  wire logic i_demag_pin_short,
    input  wire logic i_zvt_pin_open,
    input  wire logic i_zvt_pin_short,
    output var  logic o_low_side_gate_pulse,
    output var  logic o_run,
    output var  logic o_prog_bias_enable,
    output var  logic o_uvlo_force,
    output var  logic o_recovery_active,
    output var  logic o_cs_short_fault,
    output var  logic o_cs_open_fault,
    output var  logic o_bias_open_fault,
    output var  logic o_bias_over_fault,
    output var  logic o_prog_pin_fault
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pin_fault_pkg::supervisor_state_t state_ff;
    pin_fault_pkg::supervisor_state_t nxt_state;
    logic [pin_fault_pkg::N_SYNC_IN-1:0]  raw_in;
    logic [pin_fault_pkg::N_SYNC_IN-1:0]  sync_in;
    logic [pin_fault_pkg::DELAY_W-1:0]    delay_ff;
    logic [pin_fault_pkg::RECOVERY_W-1:0] recovery_ff;
    logic                                 recovery_done_ff;
    logic                                 supply_prev_ff;
    logic [pin_fault_pkg::ONTIME_W-1:0]   ontime_ff;
    logic                                 first_pulse_ff;
    logic                                 cs_seen_ff;
    logic                                 bias_seen_ff;
    logic [pin_fault_pkg::RUN_W-1:0]      cs_run_ff;
    logic [pin_fault_pkg::RUN_W-1:0]      bias_run_ff;
    logic                                 gate_ff;
    logic                                 supply_on;
    logic                                 supply_rise;
    logic                                 supply_fall;
    logic [pin_fault_pkg::ONTIME_W-1:0]   first_limit;
    logic                                 cap_hit;
    logic                                 nxt_gate;
    logic                                 pulse_end;
    logic                                 cs_hit;
    logic                                 bias_hit;
    logic                                 cs_open_trip;
    logic                                 bias_over_trip;
    logic                                 sample_now;
    logic                                 prog_fault;
    // Advances a consecutive-pulse run on a failing pulse and clears it on a passing one.
    function automatic logic [pin_fault_pkg::RUN_W-1:0] bump_run(
        input logic [pin_fault_pkg::RUN_W-1:0] run,
        input logic                            hit
    );
        bump_run = hit ? run + 2'h1 : 2'h0;
    endfunction

    // ------------------------------------------------------------------
    // Comparator inputs from the analog side
    // ------------------------------------------------------------------
    // Comparator inputs packed in the bit order of the package positions.
    assign raw_in = {i_zvt_pin_short, i_zvt_pin_open, i_demag_pin_short, i_demag_pin_open,
                     i_gate_bias_over, i_gate_bias_low, i_cs_over_limit,
                     i_demag_resistor_high, i_switch_type_select, i_supply_on};
    pin_input_filter #(
        .WIDTH (pin_fault_pkg::N_SYNC_IN)
    ) u_filter (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_raw   (raw_in),
        .o_level (sync_in)
    );

    // ------------------------------------------------------------------
    // Decoded conditions
    // ------------------------------------------------------------------
    // Supply comparator edges mark the turn-on and turn-off crossings.
    assign supply_on   = sync_in[pin_fault_pkg::IN_SUPPLY_ON];
    assign supply_rise = supply_on & ~supply_prev_ff;
    assign supply_fall = ~supply_on & supply_prev_ff;

    // First-pulse cap chosen by stage type and demag resistor range.
    assign first_limit =
        ((sync_in[pin_fault_pkg::IN_SWITCH_SEL] == pin_fault_pkg::SWITCH_SILICON)
         || sync_in[pin_fault_pkg::IN_DEMAG_HIGH])
        ? pin_fault_pkg::ONTIME_W'(pin_fault_pkg::FIRST_LIMIT_LONG_CYC)
        : pin_fault_pkg::ONTIME_W'(pin_fault_pkg::FIRST_LIMIT_SHORT_CYC);
    // A first pulse still requested after its cap is cut short and is a sense-pin short.
    assign cap_hit = first_pulse_ff & gate_ff & i_pwm_request
                   & (ontime_ff == first_limit);
    // Consecutive-pulse evaluation happens at the end of each pulse; no gate once supply drops.
    assign nxt_gate  = (state_ff == pin_fault_pkg::ST_RUN) & supply_on & i_pwm_request & ~cap_hit;
    assign pulse_end = gate_ff & ~nxt_gate;
    assign cs_hit    = cs_seen_ff | sync_in[pin_fault_pkg::IN_CS_OVER];
    assign bias_hit  = bias_seen_ff | sync_in[pin_fault_pkg::IN_BIAS_OVER];
    assign cs_open_trip   = pulse_end & cs_hit
                          & (cs_run_ff == pin_fault_pkg::RUN_TRIP_PRIOR);
    assign bias_over_trip = pulse_end & bias_hit
                          & (bias_run_ff == pin_fault_pkg::RUN_TRIP_PRIOR);
    // Startup checks are sampled once the bias settle delay has run out.
    assign sample_now = (state_ff == pin_fault_pkg::ST_CHECK)
                      & (delay_ff == pin_fault_pkg::DELAY_W'(pin_fault_pkg::BIAS_SAMPLE_CYC - 1));
    assign prog_fault = sync_in[pin_fault_pkg::IN_DEMAG_OPEN] | sync_in[pin_fault_pkg::IN_DEMAG_SHORT]
                      | sync_in[pin_fault_pkg::IN_ZVT_OPEN] | sync_in[pin_fault_pkg::IN_ZVT_SHORT];

    // ------------------------------------------------------------------
    // Supervisor sequence
    // ------------------------------------------------------------------
    // Next state: startup checks, switching, lockout and long recovery.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            pin_fault_pkg::ST_IDLE: begin
                if (supply_rise) begin
                    nxt_state = pin_fault_pkg::ST_CHECK;
                end
            end
            pin_fault_pkg::ST_CHECK: begin
                if (!supply_on) begin
                    nxt_state = pin_fault_pkg::ST_IDLE;
                end else if (sample_now && (sync_in[pin_fault_pkg::IN_BIAS_LOW] || prog_fault)) begin
                    nxt_state = pin_fault_pkg::ST_LOCKOUT;
                end else if (sample_now) begin
                    nxt_state = pin_fault_pkg::ST_RUN;
                end
            end
            pin_fault_pkg::ST_RUN: begin
                if (cap_hit || cs_open_trip) begin
                    nxt_state = pin_fault_pkg::ST_RECOVERY;
                end else if (bias_over_trip) begin
                    nxt_state = pin_fault_pkg::ST_LOCKOUT;
                end else if (!supply_on) begin
                    nxt_state = pin_fault_pkg::ST_IDLE;
                end
            end
            pin_fault_pkg::ST_LOCKOUT: begin
                if (!supply_on) begin
                    nxt_state = pin_fault_pkg::ST_IDLE;
                end
            end
            pin_fault_pkg::ST_RECOVERY: begin
                if (recovery_done_ff && supply_fall) begin
                    nxt_state = pin_fault_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = pin_fault_pkg::ST_IDLE;
            end
        endcase
    end
    // State register and supply edge history.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff       <= pin_fault_pkg::ST_IDLE;
            supply_prev_ff <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            supply_prev_ff <= supply_on;
        end
    end
    // Settle delay counter, running only while the startup checks are pending.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            delay_ff <= '0;
        end else if (state_ff == pin_fault_pkg::ST_CHECK) begin
            delay_ff <= delay_ff + 7'h01;
        end else begin
            delay_ff <= '0;
        end
    end
    // Recovery timer; the done flag waits for the next turn-off crossing.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            recovery_ff      <= '0;
            recovery_done_ff <= 1'b0;
        end else if (state_ff != pin_fault_pkg::ST_RECOVERY) begin
            recovery_ff      <= '0;
            recovery_done_ff <= 1'b0;
        end else if (!recovery_done_ff) begin
            recovery_ff <= recovery_ff + 24'h000001;
            if (recovery_ff == pin_fault_pkg::RECOVERY_W'(RECOVERY_CYCLES - 1)) begin
                recovery_done_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Low-side pulse supervision
    // ------------------------------------------------------------------
    // Gate, on-time count and first-pulse flag, re-armed at each turn-on.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gate_ff        <= 1'b0;
            ontime_ff      <= '0;
            first_pulse_ff <= 1'b0;
        end else begin
            gate_ff <= nxt_gate;
            if (nxt_gate) begin
                ontime_ff <= gate_ff ? ontime_ff + 5'h01 : 5'h01;
            end else begin
                ontime_ff <= '0;
            end
            if (state_ff == pin_fault_pkg::ST_CHECK) begin
                first_pulse_ff <= 1'b1;
            end else if (pulse_end) begin
                first_pulse_ff <= 1'b0;
            end
        end
    end
    // Comparator hits caught during a pulse, cleared at the start of the next.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_seen_ff   <= 1'b0;
            bias_seen_ff <= 1'b0;
        end else if (nxt_gate && !gate_ff) begin
            cs_seen_ff   <= 1'b0;
            bias_seen_ff <= 1'b0;
        end else if (gate_ff) begin
            cs_seen_ff   <= cs_hit;
            bias_seen_ff <= bias_hit;
        end
    end
    // Consecutive-pulse runs; cleared outside switching and on any passing pulse.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_run_ff   <= '0;
            bias_run_ff <= '0;
        end else if (state_ff != pin_fault_pkg::ST_RUN) begin
            cs_run_ff   <= '0;
            bias_run_ff <= '0;
        end else if (pulse_end) begin
            cs_run_ff   <= bump_run(cs_run_ff, cs_hit);
            bias_run_ff <= bump_run(bias_run_ff, bias_hit);
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    // Level outputs follow the next state so they line up with it.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_low_side_gate_pulse <= 1'b0;
            o_run                 <= 1'b0;
            o_prog_bias_enable    <= 1'b0;
            o_uvlo_force          <= 1'b0;
            o_recovery_active     <= 1'b0;
        end else begin
            o_low_side_gate_pulse <= nxt_gate;
            o_run                 <= (nxt_state == pin_fault_pkg::ST_RUN);
            o_prog_bias_enable    <= (nxt_state == pin_fault_pkg::ST_CHECK);
            o_uvlo_force          <= (nxt_state == pin_fault_pkg::ST_LOCKOUT)
                                   | (nxt_state == pin_fault_pkg::ST_RECOVERY);
            o_recovery_active     <= (nxt_state == pin_fault_pkg::ST_RECOVERY);
        end
    end
    // One-cycle fault pulses naming the cause of each shutdown.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cs_short_fault  <= 1'b0;
            o_cs_open_fault   <= 1'b0;
            o_bias_open_fault <= 1'b0;
            o_bias_over_fault <= 1'b0;
            o_prog_pin_fault  <= 1'b0;
        end else begin
            o_cs_short_fault  <= cap_hit;
            o_cs_open_fault   <= cs_open_trip & ~cap_hit;
            o_bias_open_fault <= sample_now & supply_on & sync_in[pin_fault_pkg::IN_BIAS_LOW];
            o_bias_over_fault <= bias_over_trip & ~cap_hit & ~cs_open_trip;
            o_prog_pin_fault  <= sample_now & supply_on & prog_fault;
        end
    end
endmodule

`default_nettype wire

// ### shared/pin_fault_pkg.sv
// Shared constants, timing counts and state encoding for the pin-fault supervisor.
package pin_fault_pkg;

    // ------------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------------
    localparam int     CLK_PERIOD_NS        = 100;
    localparam int     FIRST_LIMIT_LONG_NS  = 2000;
    localparam int     FIRST_LIMIT_SHORT_NS = 1000;
    localparam int     BIAS_SAMPLE_DELAY_NS = 10000;
    localparam longint RECOVERY_DELAY_MS    = 1500;

    // Longest times round down, least times round up.
    localparam int     FIRST_LIMIT_LONG_CYC  = FIRST_LIMIT_LONG_NS / CLK_PERIOD_NS;
    localparam int     FIRST_LIMIT_SHORT_CYC = FIRST_LIMIT_SHORT_NS / CLK_PERIOD_NS;
    localparam int     BIAS_SAMPLE_CYC       =
        (BIAS_SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint RECOVERY_CYC_L        = RECOVERY_DELAY_MS * 64'd1000000 / CLK_PERIOD_NS;
    localparam int     RECOVERY_CYC          = int'(RECOVERY_CYC_L);

    // ------------------------------------------------------------------
    // Counter widths and limits
    // ------------------------------------------------------------------
    localparam int         ONTIME_W       = 5;
    localparam int         DELAY_W        = 7;
    localparam int         RECOVERY_W     = 24;
    localparam int         RUN_W          = 2;
    localparam logic [1:0] RUN_TRIP_PRIOR = 2'h2;

    // Level of the switch-type select that marks a silicon stage.
    localparam logic SWITCH_SILICON = 1'b1;

    // ------------------------------------------------------------------
    // Bit positions of the synchronised comparator inputs
    // ------------------------------------------------------------------
    localparam int IN_SUPPLY_ON   = 0;
    localparam int IN_SWITCH_SEL  = 1;
    localparam int IN_DEMAG_HIGH  = 2;
    localparam int IN_CS_OVER     = 3;
    localparam int IN_BIAS_LOW    = 4;
    localparam int IN_BIAS_OVER   = 5;
    localparam int IN_DEMAG_OPEN  = 6;
    localparam int IN_DEMAG_SHORT = 7;
    localparam int IN_ZVT_OPEN    = 8;
    localparam int IN_ZVT_SHORT   = 9;
    localparam int N_SYNC_IN      = 10;

    // ------------------------------------------------------------------
    // Supervisor states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_CHECK    = 3'h1,
        ST_RUN      = 3'h2,
        ST_LOCKOUT  = 3'h3,
        ST_RECOVERY = 3'h4
    } supervisor_state_t;

endpackage

// ### rtl/pin_input_filter.sv
// Three-flop synchroniser bank that accepts a change once the last two stages agree.
`timescale 1ns/1ps
`default_nettype none

module pin_input_filter #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_raw,
    output var  logic [WIDTH-1:0] o_level
);

    // ------------------------------------------------------------------
    // One synchroniser per input bit
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic stage1_ff;
            logic stage2_ff;
            logic stage3_ff;

            // The first stage feeds only the second; the level moves when stages agree.
            always_ff @(posedge i_mclk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    stage1_ff  <= 1'b0;
                    stage2_ff  <= 1'b0;
                    stage3_ff  <= 1'b0;
                    o_level[g] <= 1'b0;
                end else begin
                    stage1_ff <= i_raw[g];
                    stage2_ff <= stage1_ff;
                    stage3_ff <= stage2_ff;
                    if (stage2_ff == stage3_ff) begin
                        o_level[g] <= stage3_ff;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ### tb/pin_fault_properties.sv
// Concurrent checks on the output relations of the pin-fault supervisor.
`timescale 1ns/1ps
`default_nettype none

module pin_fault_properties #(
    parameter int unsigned RECOVERY_CYCLES = 50
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_switch_type_select,
    input wire logic i_demag_resistor_high,
    input wire logic o_low_side_gate_pulse,
    input wire logic o_run,
    input wire logic o_prog_bias_enable,
    input wire logic o_uvlo_force,
    input wire logic o_recovery_active,
    input wire logic o_cs_short_fault,
    input wire logic o_cs_open_fault,
    input wire logic o_bias_open_fault,
    input wire logic o_bias_over_fault,
    input wire logic o_prog_pin_fault
);
    logic [7:0]  bias_len_ff;
    logic [7:0]  gate_len_ff;
    logic [15:0] rec_len_ff;
    int          cap_cyc;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    // First-pulse cap expected from the stage type and the demag range.
    assign cap_cyc = (i_switch_type_select == pin_fault_pkg::SWITCH_SILICON
                      || i_demag_resistor_high) ? pin_fault_pkg::FIRST_LIMIT_LONG_CYC
                                                : pin_fault_pkg::FIRST_LIMIT_SHORT_CYC;

    // Counters of how long each level has stood, cleared when it drops.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bias_len_ff <= 8'h00;
            gate_len_ff <= 8'h00;
            rec_len_ff  <= 16'h0000;
        end else begin
            bias_len_ff <= o_prog_bias_enable ? bias_len_ff + 8'h01 : 8'h00;
            gate_len_ff <= o_low_side_gate_pulse ? gate_len_ff + 8'h01 : 8'h00;
            rec_len_ff  <= o_recovery_active ? rec_len_ff + 16'h0001 : 16'h0000;
        end
    end

    chk_gate_needs_run: assert property (o_low_side_gate_pulse |-> o_run)
        else $error("gate pulse outside run");
    chk_short_cap_len: assert property ($rose(o_cs_short_fault) |->
        int'(gate_len_ff) == cap_cyc && !o_low_side_gate_pulse)
        else $error("first pulse cap length wrong");
    chk_short_to_recov: assert property (o_cs_short_fault |->
        o_recovery_active && o_uvlo_force && !o_run)
        else $error("sense short without recovery");
    chk_open_to_recov: assert property (o_cs_open_fault |-> o_recovery_active && !o_run)
        else $error("sense open without recovery");
    chk_fault_one_cyc: assert property ((o_cs_short_fault || o_cs_open_fault) |=>
        !(o_cs_short_fault || o_cs_open_fault))
        else $error("fault pulse longer than one cycle");
    chk_lockout_faults: assert property ((o_bias_open_fault || o_bias_over_fault
        || o_prog_pin_fault) |-> o_uvlo_force && !o_recovery_active && !o_run)
        else $error("lockout fault without lockout");
    chk_check_window: assert property ($fell(o_prog_bias_enable) |-> bias_len_ff == 8'h64)
        else $error("pin check window not 100 cycles");
    chk_check_exit: assert property ($fell(o_prog_bias_enable) |-> o_run ^ o_uvlo_force)
        else $error("pin check left without run or lockout");
    chk_recov_length: assert property ($fell(o_recovery_active) |->
        32'(rec_len_ff) >= RECOVERY_CYCLES)
        else $error("recovery ended early");
    chk_lockout_no_run: assert property (o_uvlo_force |-> !o_run && !o_prog_bias_enable)
        else $error("run during lockout");

    cov_short: cover property (o_cs_short_fault);
    cov_open: cover property (o_cs_open_fault);
    cov_over: cover property (o_bias_over_fault);
    cov_prog: cover property (o_prog_pin_fault);
endmodule

bind pin_fault_protection pin_fault_properties #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_props (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_switch_type_select(i_switch_type_select),
    .i_demag_resistor_high(i_demag_resistor_high), .o_low_side_gate_pulse(o_low_side_gate_pulse),
    .o_run(o_run), .o_prog_bias_enable(o_prog_bias_enable), .o_uvlo_force(o_uvlo_force),
    .o_recovery_active(o_recovery_active), .o_cs_short_fault(o_cs_short_fault),
    .o_cs_open_fault(o_cs_open_fault), .o_bias_open_fault(o_bias_open_fault),
    .o_bias_over_fault(o_bias_over_fault), .o_prog_pin_fault(o_prog_pin_fault));
`default_nettype wire

// ### tb/power_stage_model.sv
// Behavioural power stage and sense network facing the pin-fault supervisor.
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
    input  wire logic i_mclk,
    input  wire logic i_gate,
    input  wire logic i_sense_open,
    input  wire logic i_bias_surge,
    output var  logic o_cs_over,
    output var  logic o_bias_over
);
    // An open sense pin is pulled up, so its comparator reads high at all times.
    assign o_cs_over = i_sense_open;

    // Switch-node surges charge the bias pin only while the low-side switch conducts.
    always_ff @(posedge i_mclk) begin
        o_bias_over <= i_bias_surge & i_gate;
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the pin-fault supervisor with a power-stage model.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int unsigned REC = 50;
    logic i_mclk, i_rst_b, pwm_req, sup, sel, dmg, gb_low, d_op, d_sh, z_op, z_sh;
    logic sns_open, surge, cs_over, b_over, gate, run, b_en, uvlo, recov;
    logic f_sh, f_op, f_bo, f_bv, f_pg, sh, fo, fb;
    int   miscompares, n_checks, seed, len, k;

    // Free-running clock at 100 ns.
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    pin_fault_protection #(.RECOVERY_CYCLES(REC)) u_dut (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_pwm_request(pwm_req), .i_supply_on(sup),
        .i_switch_type_select(sel), .i_demag_resistor_high(dmg), .i_cs_over_limit(cs_over),
        .i_gate_bias_low(gb_low), .i_gate_bias_over(b_over), .i_demag_pin_open(d_op),
        .i_demag_pin_short(d_sh), .i_zvt_pin_open(z_op), .i_zvt_pin_short(z_sh),
        .o_low_side_gate_pulse(gate), .o_run(run), .o_prog_bias_enable(b_en),
        .o_uvlo_force(uvlo), .o_recovery_active(recov), .o_cs_short_fault(f_sh),
        .o_cs_open_fault(f_op), .o_bias_open_fault(f_bo), .o_bias_over_fault(f_bv),
        .o_prog_pin_fault(f_pg));

    power_stage_model u_stage (.i_mclk(i_mclk), .i_gate(gate), .i_sense_open(sns_open),
        .i_bias_surge(surge), .o_cs_over(cs_over), .o_bias_over(b_over));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Advance to just after a rising edge, where inputs change and outputs are read.
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    // Raise the supply and wait, bounded, for the pin check to end.
    task automatic power_up;
        sup = 1'b1;
        for (k = 0; k < 200 && !(run === 1'b1 || uvlo === 1'b1); k++) cyc(1);
        if (k == 200) begin
            miscompares++;
            print_verdict();
        end
    endtask

    // Request one pulse of n cycles, then a quiet gap, collecting fault pulses.
    task automatic pulse(input int n);
        pwm_req = 1'b1;
        for (int i = 0; i < n + 8; i++) begin
            if (i == n) pwm_req = 1'b0;
            cyc(1);
            fo |= f_op;
            fb |= f_bv;
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 20936;
        miscompares = 0;
        n_checks = 0;
        {i_rst_b, pwm_req, sup, gb_low, d_op, d_sh, z_op, z_sh, sns_open, surge} = 10'h000;
        {sel, dmg, fo, fb} = 4'h8;
        cyc(10);
        i_rst_b = 1'b1;
        cyc(2);
        // Every start-up pin fault, then a clean start.
        for (int f = 0; f < 6; f++) begin
            {z_sh, z_op, d_sh, d_op, gb_low} = (f == 5) ? 5'h00 : 5'h01 << f;
            power_up();
            chk("lockout", uvlo, f < 5);
            chk("run", run, f == 5);
            chk("bias_open", f_bo, f == 0);
            chk("prog_fault", f_pg, f inside {[1:4]});
            sup = 1'b0;
            cyc(8);
            chk("idle", uvlo, 1'b0);
        end
        {z_sh, z_op, d_sh, d_op, gb_low} = 5'h00;
        $display("test 1 done");
        // First-pulse cap for each stage setting, then the recovery release.
        for (int c = 0; c < 3; c++) begin
            sel = (c == 0);
            dmg = (c == 1);
            cyc(6);
            power_up();
            pwm_req = 1'b1;
            len = 0;
            sh = 1'b0;
            for (k = 0; k < 40; k++) begin
                cyc(1);
                len += (gate === 1'b1);
                sh |= f_sh;
            end
            pwm_req = 1'b0;
            chk("first_len", 8'(len), (c == 2) ? 8'h0A : 8'h14);
            chk("cs_short", sh, 1'b1);
            chk("recovery", recov, 1'b1);
            sup = 1'b0;
            cyc(20);
            chk("early_fall", recov, 1'b1);
            sup = 1'b1;
            cyc(REC);
            chk("await_fall", uvlo, 1'b1);
            sup = 1'b0;
            cyc(8);
            chk("released", recov, 1'b0);
        end
        $display("test 2 done");
        // Passing first pulse, long later pulse, broken and unbroken open runs.
        sel = 1'b0;
        dmg = 1'b0;
        cyc(6);
        power_up();
        len = 4 + ($unsigned($random(seed)) % 6);
        pulse(len);
        pulse(15);
        chk("later_uncapped", run, 1'b1);
        sns_open = 1'b1;
        pulse(8);
        pulse(8);
        sns_open = 1'b0;
        cyc(6);
        pulse(8 + ($unsigned($random(seed)) % 4));
        sns_open = 1'b1;
        pulse(8);
        pulse(8);
        chk("run_broken", fo, 1'b0);
        pulse(8);
        chk("cs_open", fo, 1'b1);
        chk("open_recov", recov, 1'b1);
        sns_open = 1'b0;
        cyc(REC);
        sup = 1'b0;
        cyc(8);
        $display("test 3 done");
        // Gate-bias over-voltage on three pulses in a row.
        power_up();
        pulse(6);
        surge = 1'b1;
        pulse(8);
        pulse(8);
        chk("two_over", fb, 1'b0);
        pulse(8);
        chk("bias_over", fb, 1'b1);
        chk("over_lockout", {recov, uvlo}, 8'h01);
        surge = 1'b0;
        $display("test 4 done");
        print_verdict();
    end
endmodule
`default_nettype wire
